/* File: tsc_pkg.sv */
// What this block does
// [R1] counter equals compare: set match flags
// [R2] write one clears flag, zero keeps
// [R3] wake flag set when match woke sleeper
// [R4] count register reads live 24-bit counter
// [R5] enabled capture edge sets flag, stores count
// [R6] edge select: fall, rise, both, reserved
// [R7] reset-on-capture clears counter after store
// [R8] capture irq enable drives irq from flag
// [R9] capture edges optionally pass debounce filter
// [R10] event counting edges optionally debounced
// [R11] mode bit: free capture or trigger-counting
// [R12] source bit: pin or 32 kHz clock
// [R13] capture irq flag bit0, write-one clear
// [R14] reserved bits read zero, writes ignored
//
// Purpose: shared constants and types of the timer status and capture unit
// Assumes: avalon-mm byte addresses, one 32-bit word per register
// Notes:   all timing derives from the 50 MHz system clock
package tsc_pkg;

	// register byte offsets
	localparam logic [4:0] TSC_OFS_CONTROL     = 5'h00;
	localparam logic [4:0] TSC_OFS_COMPARE     = 5'h04;
	localparam logic [4:0] TSC_OFS_FLAGS       = 5'h08;
	localparam logic [4:0] TSC_OFS_COUNT       = 5'h0c;
	localparam logic [4:0] TSC_OFS_CAPTURE     = 5'h10;
	localparam logic [4:0] TSC_OFS_CAP_CONTROL = 5'h14;
	localparam logic [4:0] TSC_OFS_CAP_STATUS  = 5'h18;
	localparam logic [4:0] TSC_OFS_IRQ_MASK    = 5'h1c;

	// control register fields
	localparam int TSC_CTL_COUNT_ENABLE  = 30;
	localparam int TSC_CTL_MATCH_IRQ_EN  = 29;
	localparam int TSC_CTL_EVENT_COUNT   = 24;
	localparam int TSC_CTL_WAKE_ENABLE   = 23;
	localparam int TSC_CTL_CAP_SOURCE    = 19;
	localparam logic [31:0] TSC_CTL_WMASK = 32'h6188_0000;

	// flag register fields
	localparam int TSC_FLG_MATCH     = 2;
	localparam int TSC_FLG_WAKE      = 1;
	localparam int TSC_FLG_MATCH_IRQ = 0;

	// capture control fields
	localparam int TSC_CC_MODE_SEL   = 8;
	localparam int TSC_CC_EVT_DB_EN  = 7;
	localparam int TSC_CC_CAP_DB_EN  = 6;
	localparam int TSC_CC_CAP_IRQ_EN = 5;
	localparam int TSC_CC_RST_ON_CAP = 4;
	localparam int TSC_CC_CAP_EN     = 3;
	localparam int TSC_CC_EDGE_HI    = 2;
	localparam int TSC_CC_EDGE_LO    = 1;
	localparam logic [8:0] TSC_CC_WMASK = 9'h1fe;

	// capture status fields
	localparam int TSC_CS_CAP_FLAG     = 1;
	localparam int TSC_CS_CAP_IRQ_FLAG = 0;

	// reset values
	localparam logic [31:0] TSC_RST_WORD = 32'h0000_0000;

	// debounce sampling
	localparam int TSC_CLK_PERIOD_NS   = 20;
	localparam int TSC_DB_SAMPLE_NS    = 1000;
	localparam int TSC_DB_SAMPLE_CYC   = (TSC_DB_SAMPLE_NS + TSC_CLK_PERIOD_NS - 1)
		/ TSC_CLK_PERIOD_NS;
	localparam int TSC_DIV_W           = 6;
	localparam logic [TSC_DIV_W-1:0] TSC_DIV_LAST = TSC_DIV_W'(TSC_DB_SAMPLE_CYC - 1);
	localparam int TSC_DB_DEPTH        = 3;

	typedef enum logic [1:0] {
		TSC_EDGE_FALL = 2'h0,
		TSC_EDGE_RISE = 2'h1,
		TSC_EDGE_BOTH = 2'h2,
		TSC_EDGE_RSVD = 2'h3
	} tsc_edge_sel_t;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} tsc_edge_t;

	typedef struct packed {
		logic [TSC_DB_DEPTH-1:0] samples;
		logic                    level;
		logic                    rise;
		logic                    fall;
	} tsc_filt_state_t;

	typedef struct packed {
		logic [TSC_DIV_W-1:0] cnt;
		logic                 tick;
	} tsc_div_state_t;

	typedef struct packed {
		logic [23:0] counter;
		logic [23:0] compare;
		logic [23:0] captured;
		logic [31:0] ctl;
		logic [8:0]  cap_ctl;
		logic [2:0]  flags;
		logic [2:0]  mask;
		logic [1:0]  cap_flags;
		logic        trig_started;
		logic        waitrequest;
		logic        irq;
		logic [31:0] readdata;
	} tsc_top_state_t;

	localparam tsc_top_state_t TSC_TOP_RESET = '{waitrequest: 1'b1, default: '0};

endpackage

/* File: tsc_tick_div.sv */
// Purpose: one-cycle sample enable for the debounce filters
// Assumes: single system clock
// Notes:   period set by the debounce sample constants
`timescale 1ns/1ps
module tsc_tick_div
	import tsc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	output logic      tick
);
	tsc_div_state_t s;
	tsc_div_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == TSC_DIV_LAST) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
		s.tick |=> !s.tick) else $error("sample tick lasted more than one cycle");
endmodule

/* File: tsc_edge_filter.sv */
// Purpose: optional debounce and edge detection of one input level
// Assumes: input synchronous to clk_sys
// Notes:   with debounce, level moves only after three equal samples
`timescale 1ns/1ps
module tsc_edge_filter
	import tsc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic raw,
	input  wire logic debounce_en,
	input  wire logic sample_tick,
	output tsc_edge_t edge_o
);
	tsc_filt_state_t s;
	tsc_filt_state_t next_s;

	always_comb begin
		next_s = s;
		if (sample_tick) begin
			next_s.samples = {s.samples[TSC_DB_DEPTH-2:0], raw};
		end
		if (!debounce_en) begin
			next_s.level = raw;
		end else if (sample_tick && (&next_s.samples)) begin // [R9] [R10]
			next_s.level = 1'b1;
		end else if (sample_tick && !(|next_s.samples)) begin // [R9] [R10]
			next_s.level = 1'b0;
		end
		next_s.rise = next_s.level & ~s.level;
		next_s.fall = ~next_s.level & s.level;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign edge_o = '{level: s.level, rise: s.rise, fall: s.fall};

	a_debounce_hold: assert property ( // [R9] [R10]
		@(posedge clk_sys) disable iff (!resetn)
		debounce_en && !sample_tick |=> $stable(s.level))
		else $error("debounced level moved without a sample tick");
endmodule

/* File: tsc_top.sv */
// Purpose: status flags, count readback and capture of a 24-bit up timer
// Assumes: avalon-mm slave, byte addresses, one wait cycle per access
// Notes:   inputs synchronous to clk_sys; irq is a level
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module tsc_top
	import tsc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ext_capture_pin,
	input  wire logic        clk32k_in,
	input  wire logic        ext_event_pin,
	input  wire logic        cpu_sleeping,
	output logic             irq
);
	tsc_top_state_t s;
	tsc_top_state_t next_s;

	logic      sample_tick;
	logic      cap_raw;
	tsc_edge_t cap_e;
	tsc_edge_t evt_e;

	logic          wr_accept;
	logic [31:0]   wbits;
	logic [31:0]   be_mask;
	logic          cap_en;
	logic          mode_trig;
	logic          waiting_trig;
	logic          hit_cap;
	logic          capture_now;
	logic          count_tick;
	logic          match_now;
	logic          wake_now;
	tsc_edge_sel_t edge_sel;

	// byte-lane mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// edge select decode
	function automatic logic edge_match(input tsc_edge_sel_t sel, input tsc_edge_t e);
		logic hit;
		hit = 1'b0;
		case (sel)
			TSC_EDGE_FALL: hit = e.fall; // [R6]
			TSC_EDGE_RISE: hit = e.rise; // [R6]
			TSC_EDGE_BOTH: hit = e.rise | e.fall; // [R6]
			default:       hit = 1'b0; // [R6]
		endcase
		return hit;
	endfunction

	// register read mux
	function automatic logic [31:0] read_word(input tsc_top_state_t r, input logic [4:0] a);
		logic [31:0] d;
		d = TSC_RST_WORD;
		if (a == TSC_OFS_CONTROL) begin
			d = r.ctl & TSC_CTL_WMASK; // [R14]
		end else if (a == TSC_OFS_COMPARE) begin
			d = {8'h00, r.compare};
		end else if (a == TSC_OFS_FLAGS) begin
			d = {29'h0000_0000, r.flags};
		end else if (a == TSC_OFS_COUNT) begin
			d = {8'h00, r.counter}; // [R4]
		end else if (a == TSC_OFS_CAPTURE) begin
			d = {8'h00, r.captured};
		end else if (a == TSC_OFS_CAP_CONTROL) begin
			d = {23'h00_0000, r.cap_ctl};
		end else if (a == TSC_OFS_CAP_STATUS) begin
			d = {30'h0000_0000, r.cap_flags}; // [R13]
		end else if (a == TSC_OFS_IRQ_MASK) begin
			d = {29'h0000_0000, r.mask};
		end
		return d;
	endfunction

	tsc_tick_div u_div (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.tick    (sample_tick)
	);

	tsc_edge_filter u_cap_filt (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.raw         (cap_raw),
		.debounce_en (s.cap_ctl[TSC_CC_CAP_DB_EN]), // [R9]
		.sample_tick (sample_tick),
		.edge_o      (cap_e)
	);

	tsc_edge_filter u_evt_filt (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.raw         (ext_event_pin),
		.debounce_en (s.cap_ctl[TSC_CC_EVT_DB_EN]), // [R10]
		.sample_tick (sample_tick),
		.edge_o      (evt_e)
	);

	// capture source mux
	assign cap_raw = s.ctl[TSC_CTL_CAP_SOURCE] ? clk32k_in : ext_capture_pin; // [R12]

	always_comb begin
		next_s = s;
		wr_accept = avs_write && !s.waitrequest;
		be_mask = lane_mask(avs_byteenable);
		wbits = avs_writedata & be_mask;
		cap_en = s.cap_ctl[TSC_CC_CAP_EN];
		mode_trig = s.cap_ctl[TSC_CC_MODE_SEL];
		waiting_trig = mode_trig && !s.trig_started; // [R11]
		edge_sel = tsc_edge_sel_t'(s.cap_ctl[TSC_CC_EDGE_HI:TSC_CC_EDGE_LO]);
		hit_cap = cap_en && edge_match(edge_sel, cap_e); // [R5]
		capture_now = hit_cap && !waiting_trig; // [R11]
		count_tick = s.ctl[TSC_CTL_COUNT_ENABLE] && !waiting_trig
			&& (s.ctl[TSC_CTL_EVENT_COUNT] ? evt_e.rise : 1'b1); // [R10]
		match_now = count_tick && (s.counter == s.compare); // [R1]
		wake_now = match_now && cpu_sleeping && s.ctl[TSC_CTL_MATCH_IRQ_EN]
			&& s.ctl[TSC_CTL_WAKE_ENABLE]; // [R3]

		// bus handshake: one wait cycle, then accept
		if ((avs_read || avs_write) && s.waitrequest) begin
			next_s.waitrequest = 1'b0;
			next_s.readdata = avs_read ? read_word(s, avs_address) : TSC_RST_WORD;
		end else begin
			next_s.waitrequest = 1'b1;
		end

		// software writes first, hardware sets after so sets win
		if (wr_accept) begin
			if (avs_address == TSC_OFS_CONTROL) begin
				next_s.ctl = (s.ctl & ~lane_mask(avs_byteenable))
					| (wbits & TSC_CTL_WMASK); // [R14]
			end else if (avs_address == TSC_OFS_COMPARE) begin
				next_s.compare = (s.compare & ~be_mask[23:0])
					| wbits[23:0]; // [R14]
			end else if (avs_address == TSC_OFS_FLAGS) begin
				next_s.flags = s.flags & ~wbits[2:0]; // [R2]
			end else if (avs_address == TSC_OFS_CAP_CONTROL) begin
				next_s.cap_ctl = (s.cap_ctl & ~be_mask[8:0])
					| (wbits[8:0] & TSC_CC_WMASK); // [R14]
			end else if (avs_address == TSC_OFS_CAP_STATUS) begin
				next_s.cap_flags = s.cap_flags & ~wbits[1:0]; // [R13]
			end else if (avs_address == TSC_OFS_IRQ_MASK) begin
				next_s.mask = wbits[2:0];
			end
		end

		// trigger-counting arms again whenever capture is off
		if (!cap_en || !mode_trig) begin
			next_s.trig_started = 1'b0;
		end

		// counter: capture reset, trigger start, then counting
		if (capture_now) begin
			next_s.captured = s.counter; // [R5]
			next_s.cap_flags[TSC_CS_CAP_IRQ_FLAG] = 1'b1; // [R5] [R13]
			next_s.cap_flags[TSC_CS_CAP_FLAG] = 1'b1;
			if (s.cap_ctl[TSC_CC_RST_ON_CAP]) begin
				next_s.counter = '0; // [R7]
			end else if (count_tick) begin
				next_s.counter = match_now ? 24'h00_0000 : s.counter + 24'h00_0001;
			end
		end else if (waiting_trig) begin
			next_s.counter = '0; // [R11]
			if (hit_cap) begin
				next_s.trig_started = 1'b1; // [R11]
			end
		end else if (count_tick) begin
			next_s.counter = match_now ? 24'h00_0000 : s.counter + 24'h00_0001;
		end

		if (match_now) begin
			next_s.flags[TSC_FLG_MATCH] = 1'b1; // [R1]
			next_s.flags[TSC_FLG_MATCH_IRQ] = 1'b1; // [R1]
		end
		if (wake_now) begin
			next_s.flags[TSC_FLG_WAKE] = 1'b1; // [R3]
		end

		// level interrupt from next flag state
		next_s.irq = (|(next_s.flags & next_s.mask))
			|| (next_s.cap_flags[TSC_CS_CAP_IRQ_FLAG]
			&& next_s.cap_ctl[TSC_CC_CAP_IRQ_EN]); // [R8]
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= TSC_TOP_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata = s.readdata;
	assign avs_waitrequest = s.waitrequest;
	assign irq = s.irq;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_match_sets_flags: assert property ( // [R1]
		match_now |=> s.flags[TSC_FLG_MATCH] && s.flags[TSC_FLG_MATCH_IRQ] && s.counter == 0)
		else $error("match did not set both match flags");

	a_flag_w1c: assert property ( // [R2]
		wr_accept && avs_address == TSC_OFS_FLAGS && avs_byteenable[0]
		&& avs_writedata[TSC_FLG_MATCH] && !match_now
		|=> !s.flags[TSC_FLG_MATCH])
		else $error("write one did not clear match flag");

	a_flag_w0_keeps: assert property ( // [R2]
		wr_accept && avs_address == TSC_OFS_FLAGS && s.flags[TSC_FLG_WAKE]
		&& !avs_writedata[TSC_FLG_WAKE] |=> s.flags[TSC_FLG_WAKE])
		else $error("write zero cleared the wake flag");

	a_wake_cause: assert property ( // [R3]
		!s.flags[TSC_FLG_WAKE] ##1 s.flags[TSC_FLG_WAKE]
		|-> $past(match_now) && $past(cpu_sleeping))
		else $error("wake flag set without a match during sleep");

	a_count_readback: assert property ( // [R4]
		avs_read && s.waitrequest && avs_address == TSC_OFS_COUNT
		|=> !avs_waitrequest && avs_readdata == {8'h00, $past(s.counter)})
		else $error("count read returned wrong value");

	a_capture_loads: assert property ( // [R5]
		capture_now |=> s.captured == $past(s.counter)
		&& s.cap_flags[TSC_CS_CAP_IRQ_FLAG])
		else $error("capture did not store counter or set flag");

	a_edge_reserved: assert property ( // [R6]
		edge_sel == TSC_EDGE_RSVD || !cap_en |-> !hit_cap)
		else $error("capture hit with reserved edge or capture off");

	a_reset_on_cap: assert property ( // [R7]
		capture_now && s.cap_ctl[TSC_CC_RST_ON_CAP] |=> s.counter == 0)
		else $error("counter not reset after capture");

	a_cap_irq_level: assert property ( // [R8]
		s.cap_flags[TSC_CS_CAP_IRQ_FLAG] && s.cap_ctl[TSC_CC_CAP_IRQ_EN] |-> irq)
		else $error("enabled capture flag without interrupt");

	a_trig_holds: assert property ( // [R11]
		waiting_trig && !hit_cap |=> s.counter == 0 && s.captured == $past(s.captured))
		else $error("counter moved before trigger edge");

	a_cap_w1c: assert property ( // [R13]
		wr_accept && avs_address == TSC_OFS_CAP_STATUS && avs_byteenable[0]
		&& avs_writedata[TSC_CS_CAP_IRQ_FLAG] && !capture_now
		|=> !s.cap_flags[TSC_CS_CAP_IRQ_FLAG])
		else $error("write one did not clear capture irq flag");

	a_reserved_zero: assert property ( // [R14]
		(s.ctl & ~TSC_CTL_WMASK) == 32'h0000_0000)
		else $error("reserved control bits became set");

	a_count_up: assert property ( // [R1]
		count_tick && !capture_now && !match_now
		|=> s.counter == $past(s.counter) + 24'h00_0001)
		else $error("counter did not step by one");

	a_wake_w1c: assert property ( // [R2]
		wr_accept && avs_address == TSC_OFS_FLAGS && avs_byteenable[0]
		&& avs_writedata[TSC_FLG_WAKE] && !wake_now |=> !s.flags[TSC_FLG_WAKE])
		else $error("write one did not clear wake flag");

	a_irq_quiet: assert property ( // [R8]
		!(|(s.flags & s.mask)) && !(s.cap_flags[TSC_CS_CAP_IRQ_FLAG]
		&& s.cap_ctl[TSC_CC_CAP_IRQ_EN]) |-> !irq)
		else $error("interrupt without an enabled flag");

	a_event_hold: assert property ( // [R10]
		s.ctl[TSC_CTL_COUNT_ENABLE] && s.ctl[TSC_CTL_EVENT_COUNT] && !evt_e.rise
		&& !capture_now && !waiting_trig |=> s.counter == $past(s.counter))
		else $error("event counter moved without an event edge");

	a_src_clk32: assert property ( // [R12]
		!s.cap_ctl[TSC_CC_CAP_DB_EN] && s.ctl[TSC_CTL_CAP_SOURCE]
		|=> cap_e.level == $past(clk32k_in))
		else $error("capture input did not follow slow clock");

	a_src_pin: assert property ( // [R12]
		!s.cap_ctl[TSC_CC_CAP_DB_EN] && !s.ctl[TSC_CTL_CAP_SOURCE]
		|=> cap_e.level == $past(ext_capture_pin))
		else $error("capture input did not follow capture pin");

	a_cap_w0_keeps: assert property ( // [R13]
		wr_accept && avs_address == TSC_OFS_CAP_STATUS && s.cap_flags[TSC_CS_CAP_FLAG]
		&& !avs_writedata[TSC_CS_CAP_FLAG] |=> s.cap_flags[TSC_CS_CAP_FLAG])
		else $error("write zero cleared the capture flag");
endmodule

/* File: tsc_pin_model.sv */
// Purpose: far-side model of capture pin, slow clock and event pin
// Assumes: levels requested by the bench, one clk_sys of delay
// Notes:   slow clock stands at 0 while not running
`timescale 1ns/1ps
module tsc_pin_model #(
	parameter int HALF32 = 8
) (
	input  wire logic clk_sys,
	input  wire logic cap_lvl,
	input  wire logic evt_lvl,
	input  wire logic run32,
	output logic      ext_capture_pin,
	output logic      clk32k_in,
	output logic      ext_event_pin
);
	int div = 0;
	always @(posedge clk_sys) begin
		ext_capture_pin <= cap_lvl;
		ext_event_pin   <= evt_lvl;
		div             <= (run32 && div < HALF32 - 1) ? div + 1 : 0;
		if (!run32)
			clk32k_in <= 1'b0;
		else if (div == HALF32 - 1)
			clk32k_in <= ~clk32k_in;
	end
endmodule

/* File: tb_tsc_top.sv */
// Purpose: register-level bench of the timer status and capture unit
// Assumes: master waits for waitrequest low, pins synchronous to clk_sys
// Notes:   counter cleared by a second reset before event counting
`timescale 1ns/1ps
module tb_tsc_top
	import tsc_pkg::*;
;
	logic        clk_sys;
	logic        resetn;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ext_capture_pin;
	logic        clk32k_in;
	logic        ext_event_pin;
	logic        cpu_sleeping;
	logic        irq;
	logic        cap_lvl;
	logic        evt_lvl;
	logic        run32;
	logic [31:0] r;
	int          err_count;
	int          cmp_count;
	int          cyc;

	tsc_top tsc_top_inst (
		.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_capture_pin(ext_capture_pin),
		.clk32k_in(clk32k_in), .ext_event_pin(ext_event_pin),
		.cpu_sleeping(cpu_sleeping), .irq(irq)
	);
	tsc_pin_model tsc_pin_model_inst (
		.clk_sys(clk_sys), .cap_lvl(cap_lvl), .evt_lvl(evt_lvl), .run32(run32),
		.ext_capture_pin(ext_capture_pin), .clk32k_in(clk32k_in),
		.ext_event_pin(ext_event_pin)
	);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_read      <= !w;
		avs_write     <= w;
		avs_writedata <= d;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		r = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			evt_lvl <= 1'b1;
			waitc(6);
			evt_lvl <= 1'b0;
			waitc(6);
		end
	endtask
	task automatic cap_wait(input logic lvl, input int n);
		cap_lvl <= lvl;
		waitc(n);
	endtask
	task automatic do_reset();
		resetn <= 1'b0;
		waitc(6);
		resetn <= 1'b1;
	endtask

	initial begin
		resetn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		cpu_sleeping = 1'b0;
		cap_lvl = 1'b0;
		evt_lvl = 1'b0;
		run32 = 1'b0;
		err_count = 0;
		cmp_count = 0;
		cyc = 0;
		do_reset();
		for (int i = 2; i < 6; i++)
			rd(5'(i * 4), 32'h0);
		wr(TSC_OFS_CAP_CONTROL, 32'hffff_ffff);
		rd(TSC_OFS_CAP_CONTROL, 32'h1fe);
		wr(TSC_OFS_CAP_CONTROL, 32'h0);
		// match flags, write-one clear, wake
		wr(TSC_OFS_IRQ_MASK, 32'h7);
		wr(TSC_OFS_COMPARE, 32'h5);
		wr(TSC_OFS_CONTROL, 32'h4000_0000);
		waitc(20);
		wr(TSC_OFS_CONTROL, 32'h0);
		rd(TSC_OFS_FLAGS, 32'h5);
		chk(32'(irq), 32'h1);
		wr(TSC_OFS_FLAGS, 32'h4);
		rd(TSC_OFS_FLAGS, 32'h1);
		wr(TSC_OFS_FLAGS, 32'h0);
		rd(TSC_OFS_FLAGS, 32'h1);
		wr(TSC_OFS_FLAGS, 32'h1);
		rd(TSC_OFS_FLAGS, 32'h0);
		waitc(2);
		chk(32'(irq), 32'h0);
		cpu_sleeping <= 1'b1;
		wr(TSC_OFS_CONTROL, 32'h6080_0000);
		waitc(20);
		wr(TSC_OFS_CONTROL, 32'h0);
		cpu_sleeping <= 1'b0;
		rd(TSC_OFS_FLAGS, 32'h7);
		wr(TSC_OFS_FLAGS, 32'h7);
		wr(TSC_OFS_CONTROL, 32'h6080_0000);
		waitc(20);
		wr(TSC_OFS_CONTROL, 32'h0);
		rd(TSC_OFS_FLAGS, 32'h5);
		// event counting, plain and filtered
		do_reset();
		wr(TSC_OFS_COMPARE, 32'hff_ffff);
		wr(TSC_OFS_CONTROL, 32'h4100_0000);
		pulse(3);
		rd(TSC_OFS_COUNT, 32'h3);
		wr(TSC_OFS_COUNT, 32'h55);
		rd(TSC_OFS_COUNT, 32'h3);
		wr(TSC_OFS_CAP_CONTROL, 32'h80);
		evt_lvl <= 1'b1;
		waitc(3);
		evt_lvl <= 1'b0;
		waitc(250);
		evt_lvl <= 1'b1;
		waitc(250);
		evt_lvl <= 1'b0;
		waitc(250);
		rd(TSC_OFS_COUNT, 32'h4);
		// capture disabled, then every edge mode
		wr(TSC_OFS_CAP_CONTROL, 32'h2);
		cap_wait(1'b1, 8);
		rd(TSC_OFS_CAP_STATUS, 32'h0);
		cap_wait(1'b0, 8);
		for (int e = 0; e < 3; e++) begin
			wr(TSC_OFS_CAP_STATUS, 32'h3);
			wr(TSC_OFS_CAP_CONTROL, 32'(8 + 2 * e));
			cap_wait(1'b1, 8);
			rd(TSC_OFS_CAP_STATUS, (e != 0) ? 32'h3 : 32'h0);
			wr(TSC_OFS_CAP_STATUS, 32'h3);
			cap_wait(1'b0, 8);
			rd(TSC_OFS_CAP_STATUS, (e != 1) ? 32'h3 : 32'h0);
		end
		wr(TSC_OFS_CAP_STATUS, 32'h3);
		wr(TSC_OFS_CAP_CONTROL, 32'he);
		cap_wait(1'b1, 8);
		cap_wait(1'b0, 8);
		rd(TSC_OFS_CAP_STATUS, 32'h0);
		rd(TSC_OFS_CAPTURE, 32'h4);
		// capture interrupt enable
		wr(TSC_OFS_CAP_STATUS, 32'h3);
		wr(TSC_OFS_CAP_CONTROL, 32'h2a);
		cap_wait(1'b1, 8);
		chk(32'(irq), 32'h1);
		wr(TSC_OFS_CAP_CONTROL, 32'ha);
		waitc(2);
		chk(32'(irq), 32'h0);
		wr(TSC_OFS_CAP_STATUS, 32'h1);
		rd(TSC_OFS_CAP_STATUS, 32'h2);
		cap_wait(1'b0, 8);
		// reset on capture
		pulse(2);
		wr(TSC_OFS_CAP_STATUS, 32'h3);
		wr(TSC_OFS_CAP_CONTROL, 32'h1a);
		cap_wait(1'b1, 8);
		rd(TSC_OFS_CAPTURE, 32'h6);
		rd(TSC_OFS_COUNT, 32'h0);
		cap_wait(1'b0, 8);
		// slow clock as source
		wr(TSC_OFS_CAP_CONTROL, 32'ha);
		wr(TSC_OFS_CONTROL, 32'h4108_0000);
		wr(TSC_OFS_CAP_STATUS, 32'h3);
		cap_wait(1'b1, 8);
		cap_wait(1'b0, 8);
		rd(TSC_OFS_CAP_STATUS, 32'h0);
		run32 <= 1'b1;
		waitc(40);
		run32 <= 1'b0;
		waitc(8);
		rd(TSC_OFS_CAP_STATUS, 32'h3);
		// filtered capture
		wr(TSC_OFS_CONTROL, 32'h4100_0000);
		wr(TSC_OFS_CAP_CONTROL, 32'h4a);
		wr(TSC_OFS_CAP_STATUS, 32'h3);
		cap_wait(1'b1, 3);
		cap_wait(1'b0, 250);
		rd(TSC_OFS_CAP_STATUS, 32'h0);
		cap_wait(1'b1, 250);
		rd(TSC_OFS_CAP_STATUS, 32'h3);
		cap_wait(1'b0, 250);
		// trigger-counting mode
		wr(TSC_OFS_CAP_CONTROL, 32'h10a);
		wr(TSC_OFS_CAP_STATUS, 32'h3);
		wr(TSC_OFS_CONTROL, 32'h4000_0000);
		waitc(10);
		rd(TSC_OFS_COUNT, 32'h0);
		cap_wait(1'b1, 8);
		rd(TSC_OFS_CAP_STATUS, 32'h0);
		acc(1'b0, TSC_OFS_COUNT, 32'h0);
		chk(32'(r != 32'h0), 32'h1);
		final_report();
	end
endmodule
